// ---- hw/instr_cycle_timing.v ----
// instruction timing sequencer: machine cycles, address strobe, timer tick
`timescale 1ns/1ns
`include "instr_cycle_timing_defs.vh"

module instr_cycle_timing
(
    input wire I_CLK_SYS,
    input wire I_RST,
    input wire [7:0] I_OPCODE,
    input wire I_TMR_FAST,
    output reg O_ADDR_STROBE,
    output reg O_FETCH,
    output reg [2:0] O_MCYCLES,
    output reg [1:0] O_OPERAND_BYTES,
    output reg O_IMM16,
    output reg O_ADDR11,
    output reg O_ADDR16,
    output reg O_REL_OFFSET,
    output reg O_INDIRECT,
    output reg O_PTR_SEL,
    output reg O_TMR_TICK
);

// ****************************************
// opcode decoding
// ****************************************
// instruction length in bytes, standard encoding
// three-byte forms come first so the wider patterns further down never shadow them
function [1:0] op_len;
    input [7:0] op;
    begin
        op_len = 2'h1;
        casez (op)
            // long jump and call, 16-bit pointer load, bit-test branches
            8'h02, 8'h12, 8'h90: op_len = 2'h3;
            8'h10, 8'h20, 8'h30: op_len = 2'h3;
            // direct with immediate, direct to direct
            8'h43, 8'h53, 8'h63, 8'h75, 8'h85: op_len = 2'h3;
            // compare-and-jump, decrement-and-jump on a direct address
            8'hb4, 8'hb5, 8'hb6, 8'hb7: op_len = 2'h3;
            8'hb8, 8'hb9, 8'hba, 8'hbb: op_len = 2'h3;
            8'hbc, 8'hbd, 8'hbe, 8'hbf: op_len = 2'h3;
            8'hd5: op_len = 2'h3;
            // absolute jump and call: the target is split over opcode and one byte
            8'b???0_0001: op_len = 2'h2;
            8'b???1_0001: op_len = 2'h2;
            // decrement bank register and jump
            8'b1101_1???: op_len = 2'h2;
            // relative branches
            8'h40, 8'h50, 8'h60, 8'h70, 8'h80: op_len = 2'h2;
            // bit operand forms
            8'h72, 8'h82, 8'h92: op_len = 2'h2;
            8'ha0, 8'ha2, 8'hb0, 8'hb2: op_len = 2'h2;
            8'hc2, 8'hd2: op_len = 2'h2;
            // direct operand with accumulator, bank or indirect register
            8'b1010_1???: op_len = 2'h2;
            8'ha6, 8'ha7: op_len = 2'h2;
            8'hc0, 8'hd0, 8'hc5: op_len = 2'h2;
            8'h42, 8'h52, 8'h62: op_len = 2'h2;
            8'he5, 8'hf5: op_len = 2'h2;
            // single-byte accumulator operations that share the immediate column
            8'h04, 8'h14, 8'h84, 8'ha4: op_len = 2'h1;
            8'hc4, 8'hd4, 8'he4, 8'hf4: op_len = 2'h1;
            // remaining immediate-to-accumulator forms
            8'b????_0100: op_len = 2'h2;
            // direct-address column
            8'b????_0101: op_len = 2'h2;
            // immediate to bank or indirect register
            8'b0111_1???: op_len = 2'h2;
            8'b0111_011?: op_len = 2'h2;
            // direct from indirect or bank register
            8'b1000_011?: op_len = 2'h2;
            8'b1000_1???: op_len = 2'h2;
            default: op_len = 2'h1;
        endcase
    end
endfunction

// machine cycles per opcode
function [2:0] op_cycles;
    input [7:0] op;
    reg [2:0] n;
    begin
        n = {1'b0, op_len(op)};
        case (op)
            // multiply and divide by b
            8'ha4: n = `MC_MULDIV;
            8'h84: n = `MC_MULDIV;
            // 16-bit data pointer increment
            8'ha3: n = `MC_INC_PTR;
            // external data moves through the data pointer or an indirect register
            8'he0, 8'hf0: n = `MC_XDATA;
            8'he2, 8'he3: n = `MC_XDATA;
            8'hf2, 8'hf3: n = `MC_XDATA;
            // direct to direct move
            8'h85: n = `MC_MOV_DD;
            default: n = n;
        endcase
        if (n == 3'h0)
            n = 3'h1;
        op_cycles = n;
    end
endfunction

// ****************************************
// pin input synchronisers
// ****************************************
reg [7:0] op_meta;
reg [7:0] op_sync;
reg fast_meta;
reg fast_sync;
// two flops per pin; only the second stage is read by the logic below
always @(posedge I_CLK_SYS or posedge I_RST)
begin
    if (I_RST)
    begin
        op_meta <= 8'h00;
        op_sync <= 8'h00;
    end
    else
    begin
        op_meta <= I_OPCODE;
        op_sync <= op_meta;
    end
end

// the rate select is a slow level, so the two-flop delay costs nothing
always @(posedge I_CLK_SYS or posedge I_RST)
begin
    if (I_RST)
    begin
        fast_meta <= 1'b0;
        fast_sync <= 1'b0;
    end
    else
    begin
        fast_meta <= I_TMR_FAST;
        fast_sync <= fast_meta;
    end
end

// ****************************************
// operand decode
// ****************************************
// decoded every clock from the synchronised opcode but captured only at fetch,
// so an opcode that changes between fetches has no effect
reg [2:0] next_mcycles;
reg [1:0] next_operand_bytes;
reg next_imm16;
reg next_addr11;
reg next_addr16;
reg next_rel_offset;
reg next_indirect;
reg next_ptr_sel;
wire [7:0] op;
assign op = op_sync;
always @*
begin
    // decode only steers timing and operand fetch, never results
    next_mcycles = op_cycles(op);
    next_operand_bytes = op_len(op) - 2'h1;
    next_imm16 = (op == 8'h90);
    next_addr11 = (op[3:0] == 4'h1);
    next_addr16 = (op == 8'h02) || (op == 8'h12);
    case (op)
        8'h10, 8'h20, 8'h30, 8'h40: next_rel_offset = 1'b1;
        8'h50, 8'h60, 8'h70, 8'h80: next_rel_offset = 1'b1;
        8'hb4, 8'hb5, 8'hb6, 8'hb7: next_rel_offset = 1'b1;
        8'hb8, 8'hb9, 8'hba, 8'hbb: next_rel_offset = 1'b1;
        8'hbc, 8'hbd, 8'hbe, 8'hbf: next_rel_offset = 1'b1;
        8'hd5, 8'hd8, 8'hd9, 8'hda: next_rel_offset = 1'b1;
        8'hdb, 8'hdc, 8'hdd, 8'hde: next_rel_offset = 1'b1;
        8'hdf: next_rel_offset = 1'b1;
        default: next_rel_offset = 1'b0;
    endcase
    // external moves sit in another column, so only internal indirect forms land here
    next_indirect = (op[3:1] == 3'h3);
    next_ptr_sel = next_indirect && op[0];
end

// ****************************************
// machine cycle and instruction sequencing
// ****************************************
reg [1:0] phase;
reg [2:0] mc_left;
wire mc_end;
wire fetch_now;
assign mc_end = (phase == 2'h3);
assign fetch_now = mc_end && (mc_left == 3'h1);

// free-running phase: the strobe is registered from the last clock, so it is high in the first clock of every machine cycle but the first one out of reset
always @(posedge I_CLK_SYS or posedge I_RST)
begin
    if (I_RST)
    begin
        phase <= 2'h0;
        O_ADDR_STROBE <= 1'b0;
    end
    else
    begin
        phase <= phase + 2'h1;
        O_ADDR_STROBE <= mc_end;
    end
end

// cycles left in the current instruction; reloaded only on a fetch edge
always @(posedge I_CLK_SYS or posedge I_RST)
begin
    if (I_RST)
    begin
        mc_left <= `RST_MCYCLES;
        O_FETCH <= 1'b0;
    end
    else
    begin
        O_FETCH <= fetch_now;
        if (fetch_now)
            mc_left <= next_mcycles;
        else if (mc_end)
            mc_left <= mc_left - 3'h1;
    end
end

// ****************************************
// decode output registers
// ****************************************
// outputs hold the decode of the instruction in progress until the next fetch
always @(posedge I_CLK_SYS or posedge I_RST)
begin
    if (I_RST)
    begin
        O_MCYCLES <= `RST_MCYCLES;
        O_OPERAND_BYTES <= 2'h0;
        O_IMM16 <= 1'b0;
        O_ADDR11 <= 1'b0;
        O_ADDR16 <= 1'b0;
        O_REL_OFFSET <= 1'b0;
        O_INDIRECT <= 1'b0;
        O_PTR_SEL <= 1'b0;
    end
    else if (fetch_now)
    begin
        O_MCYCLES <= next_mcycles;
        O_OPERAND_BYTES <= next_operand_bytes;
        O_IMM16 <= next_imm16;
        O_ADDR11 <= next_addr11;
        O_ADDR16 <= next_addr16;
        O_REL_OFFSET <= next_rel_offset;
        O_INDIRECT <= next_indirect;
        O_PTR_SEL <= next_ptr_sel;
    end
end

// ****************************************
// timer increment prescaler
// ****************************************
// a slow-to-fast switch may end the running slow period early, never shorten a fast one
reg [3:0] tmr_cnt;
reg [3:0] tick_limit;
always @*
begin
    if (fast_sync)
        tick_limit = `TMR_FAST_CLKS - 4'h1;
    else
        tick_limit = `TMR_SLOW_CLKS - 4'h1;
end

// the tick is registered so it leaves the block straight from a flop
always @(posedge I_CLK_SYS or posedge I_RST)
begin
    if (I_RST)
    begin
        tmr_cnt <= 4'h0;
        O_TMR_TICK <= 1'b0;
    end
    else
    begin
        if (tmr_cnt >= tick_limit)
        begin
            tmr_cnt <= 4'h0;
            O_TMR_TICK <= 1'b1;
        end
        else
        begin
            tmr_cnt <= tmr_cnt + 4'h1;
            O_TMR_TICK <= 1'b0;
        end
    end
end

endmodule

// ---- hw/instr_cycle_timing_defs.vh ----
// constants for the instruction cycle timing sequencer
`ifndef INSTR_CYCLE_TIMING_DEFS_VH
`define INSTR_CYCLE_TIMING_DEFS_VH
`define CLKS_PER_MCYCLE 3'h4
`define TMR_SLOW_CLKS 4'hc
`define TMR_FAST_CLKS 4'h4
`define MC_MULDIV 3'h5
`define MC_INC_PTR 3'h3
`define MC_XDATA 3'h2
`define MC_MOV_DD 3'h3
`define RST_MCYCLES 3'h1
`endif

// ---- tb/instr_cycle_timing_asserts.sv ----
// checker for the instruction timing sequencer
`timescale 1ns/1ns
module instr_cycle_timing_asserts
(
    input wire I_CLK_SYS,
    input wire I_RST,
    input wire O_ADDR_STROBE,
    input wire O_FETCH,
    input wire [2:0] O_MCYCLES,
    input wire [1:0] O_OPERAND_BYTES,
    input wire O_TMR_TICK
);
    reg [4:0] gap;
    reg [2:0] mc;
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RST);
    // gap stays zero until the first fetch, so the first spacing is not judged
    always @(posedge I_CLK_SYS or posedge I_RST)
        if (I_RST) gap <= 5'h0;
        else gap <= O_FETCH ? 5'h1 : gap + {4'h0, gap != 5'h0};
    always @(posedge I_CLK_SYS)
        if (O_FETCH) mc <= O_MCYCLES;
    strobe_period_a: assert property (O_ADDR_STROBE |=> !O_ADDR_STROBE [*3] ##1 O_ADDR_STROBE)
        else $error("strobe period broken");
    fetch_strobe_a: assert property (O_FETCH |-> O_ADDR_STROBE) else $error("fetch off strobe");
    mcycle_range_a: assert property (O_FETCH |-> O_MCYCLES >= 3'h1 && O_MCYCLES <= 3'h5)
        else $error("cycle count out of range");
    byte_cycle_a: assert property (O_FETCH |-> O_MCYCLES > {1'b0, O_OPERAND_BYTES})
        else $error("fewer cycles than bytes");
    fetch_gap_a: assert property (O_FETCH && gap != 5'h0 |-> gap == {mc, 2'h0})
        else $error("fetch spacing wrong");
    decode_hold_a: assert property (!O_FETCH |-> $stable(O_MCYCLES) && $stable(O_OPERAND_BYTES))
        else $error("decode changed between fetches");
    tick_gap_a: assert property (O_TMR_TICK |=> !O_TMR_TICK [*3]) else $error("tick too soon");
    fetch_pulse_a: assert property (O_FETCH |=> !O_FETCH [*3]) else $error("fetch too soon");
    cover property (O_FETCH && O_MCYCLES == 3'h5);
    cover property (O_FETCH && O_MCYCLES == 3'h2);
    cover property (O_TMR_TICK ##4 O_TMR_TICK);
endmodule

// ---- tb/prog_mem_model.sv ----
// program memory model: one opcode per instruction, advanced after each fetch until it reaches the last entry
`timescale 1ns/1ns
module prog_mem_model
(
    input wire i_clk,
    input wire i_rst,
    input wire i_fetch,
    output reg [7:0] o_opcode
);
    reg [7:0] rom [0:14] = '{8'ha4, 8'h84, 8'ha3, 8'he0, 8'h01, 8'h85, 8'h28, 8'h26, 8'h27, 8'h25,
        8'h74, 8'h53, 8'h80, 8'h90, 8'h02};
    integer idx;
    // changing one clock after the fetch leaves the opcode settled three clocks before the next
    always @(posedge i_clk or posedge i_rst)
        if (i_rst) idx <= 0;
        else if (i_fetch && idx < 14) idx <= idx + 1;
    always @* o_opcode = rom[idx];
endmodule

// ---- tb/tb.sv ----
// testbench: per-opcode timing and decode, timer tick rate
`timescale 1ns/1ns
module tb;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg fast = 1'b0;
    wire [7:0] opcode;
    wire strobe, fetch, tick, imm16, a11, a16, rel, ind, ptr;
    wire [2:0] mcyc;
    wire [1:0] nbytes;
    integer n_mismatch = 0;
    integer checks_done = 0;
    // {cycles, length-1, imm16, addr11, addr16, rel, indirect, pointer select}
    reg [10:0] exp_tab [0:14] = '{11'h500, 11'h500, 11'h300, 11'h200, 11'h250, 11'h380, 11'h100,
        11'h102, 11'h103, 11'h240, 11'h240, 11'h380, 11'h244, 11'h3a0, 11'h388};
    always #2 clk = ~clk;
    instr_cycle_timing uut (.I_CLK_SYS(clk), .I_RST(rst), .I_OPCODE(opcode), .I_TMR_FAST(fast),
        .O_ADDR_STROBE(strobe), .O_FETCH(fetch), .O_MCYCLES(mcyc), .O_OPERAND_BYTES(nbytes),
        .O_IMM16(imm16), .O_ADDR11(a11), .O_ADDR16(a16), .O_REL_OFFSET(rel), .O_INDIRECT(ind),
        .O_PTR_SEL(ptr), .O_TMR_TICK(tick));
    prog_mem_model mem (.i_clk(clk), .i_rst(rst), .i_fetch(fetch), .o_opcode(opcode));
    task check(input [10:0] seen, input [10:0] want);
    begin
        checks_done = checks_done + 1;
        if (seen !== want)
        begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value at %0t: saw %h want %h", $time, seen, want);
        end
    end
    endtask
    task final_report;
    begin
        if (n_mismatch == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
    endtask
    // counts edges to the next pulse; a hang counts a mismatch and ends the run
    task wait_hi(input sel, output integer n);
    begin
        n = 0;
        do
        begin
            @(posedge clk);
            #1 n = n + 1;
        end while (!(sel ? tick : fetch) && n < 40);
        if (n == 40)
        begin
            n_mismatch = n_mismatch + 1;
            final_report;
        end
    end
    endtask
    task opcode_table;
        integer k, n;
    begin
        wait_hi(1'b0, n);
        for (k = 0; k < 15; k = k + 1)
        begin
            check({mcyc, nbytes, imm16, a11, a16, rel, ind, ptr}, exp_tab[k]);
            check({10'h0, strobe}, 11'h1);
            wait_hi(1'b0, n);
            check(n[10:0], {6'h0, exp_tab[k][10:8], 2'h0});
        end
    end
    endtask
    task tick_rate(input f, input [10:0] want);
        integer n;
    begin
        fast = f;
        repeat (30) @(posedge clk);
        wait_hi(1'b1, n);
        wait_hi(1'b1, n);
        check(n[10:0], want);
    end
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        opcode_table;
        tick_rate(1'b0, 11'hc);
        tick_rate(1'b1, 11'h4);
        final_report;
    end
endmodule
bind instr_cycle_timing instr_cycle_timing_asserts chk (.I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST),
    .O_ADDR_STROBE(O_ADDR_STROBE), .O_FETCH(O_FETCH), .O_MCYCLES(O_MCYCLES),
    .O_OPERAND_BYTES(O_OPERAND_BYTES), .O_TMR_TICK(O_TMR_TICK));
